/* File: hdl/rss_top.sv */
// Relay scan sequencer: register slave, scan list store, sequencer and advance strobe
`include "rss_consts.svh"
`default_nettype none
module rss_top #(
  parameter int RELAY_W = 24,
  parameter int DEPTH = 1024,
  parameter logic [15:0] SETTLE_TICKS = 16'(`RSS_SETTLE_TICKS)
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Relay drivers
  output logic [RELAY_W-1:0] relay_drive,
  // Instrument handshake
  input wire logic scan_trigger_input,
  output logic scan_advanced_strobe,
  // Star trigger and backplane trigger lines
  input wire logic star_trigger_in,
  input wire logic [7:0] trig_bus_in,
  output logic [7:0] trig_bus_out,
  output logic [7:0] trig_bus_oe
);
  localparam int AW = $clog2(DEPTH);
  localparam int ENT_W = RELAY_W + 18;
  localparam int TICK_CYC = `RSS_TICK_CYC;

  function automatic logic [31:0] rss_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++)
    begin
      rss_merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : rss_merge

  // ********************
  // Bus slave
  // ********************
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  wire logic wr_go;
  wire logic [7:0] wa;
  wire logic [7:0] ra;
  wire logic wr_hit;
  wire logic rd_hit;

  assign wr_go = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign wa = {waddr_reg[7:2], 2'h0};
  assign ra = {s_axi_araddr[7:2], 2'h0};
  assign wr_hit = (wa <= `RSS_OFF_ROUTE) && (wa != `RSS_OFF_STAT);
  assign rd_hit = (ra <= `RSS_OFF_DRIVE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        s_axi_awready <= 1'b0;
        waddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ********************
  // Register decode
  // ********************
  logic [31:0] ctrl_reg;
  logic [RELAY_W-1:0] pat_reg;
  logic [15:0] strbw_reg;
  logic [AW-1:0] last_reg;
  logic [AW-1:0] eaddr_reg;
  logic [RELAY_W-1:0] epat_reg;
  logic [15:0] route_reg;
  logic adv_flag_reg;
  logic [31:0] wm;
  wire logic wr_ctrl;
  wire logic wr_cmd;
  wire logic wr_ecfg;
  wire logic upd_cmd;
  wire logic start_cmd;
  wire logic abort_cmd;
  wire logic adv_clr;

  assign wr_ctrl = wr_go && (wa == `RSS_OFF_CTRL);
  assign wr_cmd = wr_go && (wa == `RSS_OFF_CMD) && wstrb_reg[0];
  assign wr_ecfg = wr_go && (wa == `RSS_OFF_ECFG);
  assign upd_cmd = wr_cmd && wdata_reg[`RSS_CMD_UPDATE];
  assign start_cmd = wr_cmd && wdata_reg[`RSS_CMD_START];
  assign abort_cmd = wr_cmd && wdata_reg[`RSS_CMD_ABORT];
  assign adv_clr = wr_go && (wa == `RSS_OFF_STAT) && wstrb_reg[0] && wdata_reg[`RSS_STAT_ADV];

  always_comb
  begin
    unique case (wa)
      `RSS_OFF_CTRL: wm = rss_merge(ctrl_reg, wdata_reg, wstrb_reg);
      `RSS_OFF_PAT: wm = rss_merge(32'(pat_reg), wdata_reg, wstrb_reg);
      `RSS_OFF_STRBW: wm = rss_merge(32'(strbw_reg), wdata_reg, wstrb_reg);
      `RSS_OFF_LAST: wm = rss_merge(32'(last_reg), wdata_reg, wstrb_reg);
      `RSS_OFF_EADDR: wm = rss_merge(32'(eaddr_reg), wdata_reg, wstrb_reg);
      `RSS_OFF_EPAT: wm = rss_merge(32'(epat_reg), wdata_reg, wstrb_reg);
      `RSS_OFF_ROUTE: wm = rss_merge(32'(route_reg), wdata_reg, wstrb_reg);
      default: wm = rss_merge(32'h0000_0000, wdata_reg, wstrb_reg);
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= `RSS_CTRL_RST;
      pat_reg <= '0;
      strbw_reg <= `RSS_STRBW_RST;
      last_reg <= '0;
      eaddr_reg <= '0;
      epat_reg <= '0;
      route_reg <= `RSS_ROUTE_RST;
    end
    else if (wr_go)
    begin
      if (wa == `RSS_OFF_CTRL)
        ctrl_reg <= wm;
      if (wa == `RSS_OFF_PAT)
        pat_reg <= wm[RELAY_W-1:0];
      if (wa == `RSS_OFF_STRBW)
        strbw_reg <= wm[15:0];
      if (wa == `RSS_OFF_LAST)
        last_reg <= wm[AW-1:0];
      if (wa == `RSS_OFF_EADDR)
        eaddr_reg <= wm[AW-1:0];
      if (wa == `RSS_OFF_EPAT)
        epat_reg <= wm[RELAY_W-1:0];
      if (wa == `RSS_OFF_ROUTE)
        route_reg <= wm[15:0];
      if (wr_ecfg)
        eaddr_reg <= eaddr_reg + 1'b1;
    end
  end

  // ********************
  // Scan list store
  // ********************
  logic [ENT_W-1:0] list_mem [0:DEPTH-1];
  logic [ENT_W-1:0] ent_reg;
  logic [AW-1:0] idx_next;
  wire logic ent_wait;
  wire logic ent_strb;
  wire logic [15:0] ent_delay;
  wire logic [RELAY_W-1:0] ent_pat;
  wire logic [15:0] wait_ticks;

  assign ent_wait = ent_reg[ENT_W-1];
  assign ent_strb = ent_reg[ENT_W-2];
  assign ent_delay = ent_reg[RELAY_W +: 16];
  assign ent_pat = ent_reg[RELAY_W-1:0];
  assign wait_ticks = (ent_delay > SETTLE_TICKS) ? ent_delay : SETTLE_TICKS;

  always_ff @(posedge aclk)
  begin
    if (wr_ecfg)
      list_mem[eaddr_reg] <= {wm[`RSS_ECFG_WAIT], wm[`RSS_ECFG_STRB], wm[15:0], epat_reg};
    ent_reg <= list_mem[idx_next];
  end

  // ********************
  // Sequencer
  // ********************
  rss_pkg::rss_state_t state_reg;
  rss_pkg::rss_state_t state_next;
  logic [AW-1:0] idx_reg;
  logic [15:0] timer_reg;
  logic [15:0] timer_next;
  logic [7:0] tick_cnt_reg;
  logic strb_state_reg;
  logic strb_next;
  logic [RELAY_W-1:0] relay_next;
  logic adv_set;
  logic tick_clr;
  wire logic auto_mode;
  wire logic stop;
  wire logic tick;
  wire logic strb_toggle;
  wire logic trig;
  rss_trig_if tif ();

  assign auto_mode = ctrl_reg[`RSS_CTRL_AUTO];
  assign strb_toggle = ctrl_reg[`RSS_CTRL_STRB_TOGGLE];
  assign stop = abort_cmd | ~auto_mode;
  assign tick = (tick_cnt_reg == 8'(TICK_CYC - 1));
  assign trig = tif.trig_pulse;

  always_comb
  begin
    state_next = state_reg;
    idx_next = idx_reg;
    timer_next = timer_reg;
    strb_next = strb_state_reg;
    relay_next = relay_drive;
    adv_set = 1'b0;
    tick_clr = 1'b0;
    if (tick && (timer_reg != 16'h0000))
      timer_next = timer_reg - 16'h0001;
    if (upd_cmd && !auto_mode)
      relay_next = pat_reg;
    if (stop)
    begin
      state_next = rss_pkg::RSS_IDLE;
      if (!strb_toggle)
        strb_next = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        rss_pkg::RSS_IDLE:
          if (start_cmd)
          begin
            idx_next = '0;
            state_next = rss_pkg::RSS_FETCH;
          end
        rss_pkg::RSS_FETCH:
          if (ent_wait)
            state_next = rss_pkg::RSS_WAIT;
          else
          begin
            relay_next = ent_pat;
            tick_clr = 1'b1;
            timer_next = wait_ticks;
            state_next = rss_pkg::RSS_SETTLE;
          end
        rss_pkg::RSS_WAIT:
          if (trig)
          begin
            relay_next = ent_pat;
            tick_clr = 1'b1;
            timer_next = wait_ticks;
            state_next = rss_pkg::RSS_SETTLE;
          end
        rss_pkg::RSS_SETTLE:
          if (timer_reg == 16'h0000)
          begin
            adv_set = 1'b1;
            state_next = rss_pkg::RSS_NEXT;
            if (ent_strb && strb_toggle)
              strb_next = ~strb_state_reg;
            else if (ent_strb)
            begin
              strb_next = 1'b1;
              timer_next = strbw_reg;
              tick_clr = 1'b1;
              state_next = rss_pkg::RSS_STROBE;
            end
          end
        rss_pkg::RSS_STROBE:
          if (timer_reg == 16'h0000)
          begin
            strb_next = 1'b0;
            state_next = rss_pkg::RSS_NEXT;
          end
        rss_pkg::RSS_NEXT:
          if (idx_reg != last_reg)
          begin
            idx_next = idx_reg + 1'b1;
            state_next = rss_pkg::RSS_FETCH;
          end
          else if (ctrl_reg[`RSS_CTRL_CYCLIC])
          begin
            idx_next = '0;
            state_next = rss_pkg::RSS_FETCH;
          end
          else
            state_next = rss_pkg::RSS_IDLE;
        default:
          state_next = rss_pkg::RSS_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= rss_pkg::RSS_IDLE;
      idx_reg <= '0;
      timer_reg <= 16'h0000;
      tick_cnt_reg <= 8'h00;
      strb_state_reg <= 1'b0;
      scan_advanced_strobe <= 1'b0;
      relay_drive <= '0;
      adv_flag_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      timer_reg <= timer_next;
      // Restart the divider on each timer load so no wait comes out a tick short
      tick_cnt_reg <= (tick || tick_clr) ? 8'h00 : tick_cnt_reg + 8'h01;
      strb_state_reg <= strb_next;
      scan_advanced_strobe <= strb_next ^ ctrl_reg[`RSS_CTRL_STRB_LOW];
      relay_drive <= relay_next;
      adv_flag_reg <= adv_set | (adv_flag_reg & ~adv_clr);
    end
  end

  // ********************
  // Trigger routing
  // ********************
  assign tif.src_sel = ctrl_reg[`RSS_CTRL_SRC_LSB +: 2];
  assign tif.bus_idx = ctrl_reg[`RSS_CTRL_BUSIDX_LSB +: 3];
  assign tif.fall_edge = ctrl_reg[`RSS_CTRL_TRIG_FALL];
  assign tif.armed = auto_mode && (state_reg == rss_pkg::RSS_WAIT);
  assign tif.adv_level = scan_advanced_strobe;
  assign tif.bus_en = route_reg[7:0];
  assign tif.bus_src = route_reg[15:8];

  rss_trig_route u_route (
    .aclk(aclk),
    .aresetn(aresetn),
    .scan_trigger_input(scan_trigger_input),
    .star_trigger_in(star_trigger_in),
    .trig_bus_in(trig_bus_in),
    .trig_bus_out(trig_bus_out),
    .trig_bus_oe(trig_bus_oe),
    .tif(tif)
  );

  // ********************
  // Read path
  // ********************
  wire logic [31:0] stat_word;
  wire logic [31:0] rd_word;

  assign stat_word = {{(16 - AW){1'b0}}, idx_reg, 14'h0000, adv_flag_reg, state_reg != rss_pkg::RSS_IDLE};
  assign rd_word = (ra == `RSS_OFF_CTRL) ? ctrl_reg :
                   (ra == `RSS_OFF_PAT) ? 32'(pat_reg) :
                   (ra == `RSS_OFF_STAT) ? stat_word :
                   (ra == `RSS_OFF_STRBW) ? 32'(strbw_reg) :
                   (ra == `RSS_OFF_LAST) ? 32'(last_reg) :
                   (ra == `RSS_OFF_EADDR) ? 32'(eaddr_reg) :
                   (ra == `RSS_OFF_EPAT) ? 32'(epat_reg) :
                   (ra == `RSS_OFF_ROUTE) ? 32'(route_reg) :
                   (ra == `RSS_OFF_DRIVE) ? 32'(relay_drive) : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : rss_top
`default_nettype wire

/* File: hdl/rss_consts.svh */
// Register offsets, field positions, reset values and timing counts of the relay scan sequencer
`ifndef RSS_CONSTS_SVH
`define RSS_CONSTS_SVH
// Register byte offsets
`define RSS_OFF_CTRL 8'h00
`define RSS_OFF_CMD 8'h04
`define RSS_OFF_PAT 8'h08
`define RSS_OFF_STAT 8'h0C
`define RSS_OFF_STRBW 8'h10
`define RSS_OFF_LAST 8'h14
`define RSS_OFF_EADDR 8'h18
`define RSS_OFF_EPAT 8'h1C
`define RSS_OFF_ECFG 8'h20
`define RSS_OFF_ROUTE 8'h24
`define RSS_OFF_DRIVE 8'h28
// Control fields
`define RSS_CTRL_AUTO 0
`define RSS_CTRL_CYCLIC 1
`define RSS_CTRL_TRIG_FALL 2
`define RSS_CTRL_STRB_TOGGLE 3
`define RSS_CTRL_STRB_LOW 4
`define RSS_CTRL_SRC_LSB 8
`define RSS_CTRL_BUSIDX_LSB 12
// Command, status and entry fields
`define RSS_CMD_UPDATE 0
`define RSS_CMD_START 1
`define RSS_CMD_ABORT 2
`define RSS_STAT_BUSY 0
`define RSS_STAT_ADV 1
`define RSS_STAT_IDX_LSB 16
`define RSS_ECFG_WAIT 16
`define RSS_ECFG_STRB 17
// Reset values
`define RSS_CTRL_RST 32'h0000_0000
`define RSS_STRBW_RST 16'h0002
`define RSS_ROUTE_RST 16'h0000
// Timing
`define RSS_CLK_HZ 10000000
`define RSS_TICK_US 1
`define RSS_TICK_CYC (`RSS_CLK_HZ / 1000000 * `RSS_TICK_US)
`define RSS_SETTLE_MS 5
`define RSS_SETTLE_TICKS (`RSS_SETTLE_MS * 1000 / `RSS_TICK_US)
`endif

/* File: hdl/rss_pkg.sv */
// Types of the relay scan sequencer
`default_nettype none
package rss_pkg;
  typedef enum logic [2:0] {
    RSS_IDLE = 3'h0,
    RSS_FETCH = 3'h1,
    RSS_WAIT = 3'h3,
    RSS_SETTLE = 3'h2,
    RSS_STROBE = 3'h6,
    RSS_NEXT = 3'h7
  } rss_state_t;
endpackage : rss_pkg
`default_nettype wire

/* File: hdl/rss_trig_if.sv */
// Signals between the sequencer core and the trigger routing matrix
`default_nettype none
interface rss_trig_if;
  logic [1:0] src_sel;
  logic [2:0] bus_idx;
  logic fall_edge;
  logic armed;
  logic adv_level;
  logic [7:0] bus_en;
  logic [7:0] bus_src;
  logic trig_pulse;
  modport core (output src_sel, bus_idx, fall_edge, armed, adv_level, bus_en, bus_src, input trig_pulse);
  modport route (input src_sel, bus_idx, fall_edge, armed, adv_level, bus_en, bus_src, output trig_pulse);
endinterface : rss_trig_if
`default_nettype wire

/* File: hdl/rss_trig_route.sv */
// Trigger routing matrix: input synchronisers, edge select and backplane drivers
`default_nettype none
module rss_trig_route (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Trigger pins
  input wire logic scan_trigger_input,
  input wire logic star_trigger_in,
  input wire logic [7:0] trig_bus_in,
  // Backplane trigger drivers
  output logic [7:0] trig_bus_out,
  output logic [7:0] trig_bus_oe,
  // Sequencer link
  rss_trig_if.route tif
);
  // ********************
  // Synchronise and select
  // ********************
  logic [9:0] meta_reg;
  logic [9:0] sync_reg;
  logic prev_reg;
  logic trig_pulse_reg;
  wire logic [7:0] bus_sync;
  wire logic sel_level;
  wire logic edge_seen;
  wire logic [7:0] drive_next;

  assign bus_sync = sync_reg[9:2];
  assign sel_level = (tif.src_sel == 2'h0) ? sync_reg[0] :
                     (tif.src_sel == 2'h1) ? sync_reg[1] : bus_sync[tif.bus_idx];
  assign edge_seen = tif.fall_edge ? (prev_reg & ~sel_level) : (~prev_reg & sel_level);
  assign drive_next = (tif.bus_src & {8{sync_reg[0]}}) | (~tif.bus_src & {8{tif.adv_level}});
  assign tif.trig_pulse = trig_pulse_reg;

  // ********************
  // Registers
  // ********************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= 10'h000;
      sync_reg <= 10'h000;
      prev_reg <= 1'b0;
      trig_pulse_reg <= 1'b0;
      trig_bus_out <= 8'h00;
      trig_bus_oe <= 8'h00;
    end
    else
    begin
      meta_reg <= {trig_bus_in, star_trigger_in, scan_trigger_input};
      sync_reg <= meta_reg;
      prev_reg <= sel_level;
      trig_pulse_reg <= edge_seen & tif.armed;
      trig_bus_out <= drive_next;
      trig_bus_oe <= tif.bus_en;
    end
  end
endmodule : rss_trig_route
`default_nettype wire

/* File: test/rss_instr_model.sv */
// Measurement instrument model: answers each advance with one trigger edge
`default_nettype none
module rss_instr_model (
  // Clock
  input wire logic aclk,
  // Strobe and its configuration
  input wire logic strb,
  input wire logic tgl,
  input wire logic low,
  input wire logic fall,
  // Trigger back to the sequencer
  output logic trig
);
  timeunit 1ns;
  timeprecision 1ns;
  logic s_q = 1'h0;
  logic adv;
  initial
  begin
    trig = 1'h0;
    forever
    begin
      @(posedge aclk);
      adv = strb !== s_q && (tgl || strb === !low);
      s_q = strb;
      trig <= fall;
      if (adv)
      begin
        // Measurement outlasts the strobe pulse, so the edge lands once the block waits again
        repeat ($urandom_range(30, 60)) @(posedge aclk);
        trig <= !fall;
        repeat (20) @(posedge aclk);
      end
    end
  end
endmodule : rss_instr_model
`default_nettype wire

/* File: test/rss_top_asserts.sv */
// Port checker of the relay scan sequencer
`default_nettype none
module rss_top_asserts #(
  parameter int RELAY_W = 24,
  parameter logic [15:0] SETTLE_TICKS = 16'h0003
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Relay, strobe and backplane
  input wire logic [RELAY_W-1:0] relay_drive,
  input wire logic scan_advanced_strobe,
  input wire logic [7:0] trig_bus_oe
);
  // ****
  // Cycles since the last pattern load
  // ****
  localparam int SCYC = SETTLE_TICKS * 10 - 1;
  logic [15:0] cnt;
  logic [RELAY_W-1:0] rd_q;
  always_ff @(posedge aclk)
  begin
    rd_q <= relay_drive;
    if (!aresetn)
      cnt <= 16'hFFFF;
    else if (relay_drive != rd_q)
      cnt <= 16'h0000;
    else if (cnt != 16'hFFFF)
      cnt <= cnt + 16'h0001;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_OE_RST: assert property ($rose(aresetn) |-> trig_bus_oe == 8'h00)
    else $error("Backplane drivers enabled after reset");
  AST_OE_WR: assert property ($changed(trig_bus_oe) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("Backplane enables changed without a write");
  AST_SETTLE: assert property ($changed(scan_advanced_strobe) |-> cnt >= SCYC)
    else $error("Strobe moved before the settle time");
  AST_STRB_RST: assert property ($rose(aresetn) |-> !scan_advanced_strobe && relay_drive == '0)
    else $error("Strobe or relays not idle after reset");
  AST_RLAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("Read answer late");
  AST_RDONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read answer repeated");
  AST_WSEQ: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
    |=> (!s_axi_awready && !s_axi_wready) ##1 (s_axi_bvalid && s_axi_awready))
    else $error("Write sequence wrong");
  AST_BDONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response repeated");
endmodule : rss_top_asserts
bind rss_top rss_top_asserts #(.RELAY_W(RELAY_W), .SETTLE_TICKS(SETTLE_TICKS)) i_chk (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .relay_drive(relay_drive), .scan_advanced_strobe(scan_advanced_strobe),
  .trig_bus_oe(trig_bus_oe));
`default_nettype wire

/* File: test/test_rss_top.sv */
// Testbench of the relay scan sequencer
`include "rss_consts.svh"
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module test_rss_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Signals and instances
  // ****
  localparam int N = 4;
  localparam logic [15:0] ST = 16'h0003;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, scan_advanced_strobe, mdl_trig;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic [23:0] relay_drive, x, pat[N];
  logic [23:0] r_q = 24'h000000;
  logic [15:0] dly[N];
  logic [7:0] trig_bus_out, trig_bus_oe, rr;
  logic ovr = 1'h1, ov = 1'h0, tgl = 1'h0, low = 1'h0, fall = 1'h0, mon = 1'h0, tseen = 1'h0, s_q = 1'h0, t_q = 1'h0;
  int n_mismatch = 0, n_checks = 0, cyc = 0, cur = 0, nld = 0, ld = 0, ac = 0;
  wire logic scan_trigger_input = ovr ? ov : mdl_trig;
  rss_top #(.SETTLE_TICKS(ST)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .relay_drive(relay_drive), .scan_trigger_input(scan_trigger_input),
    .scan_advanced_strobe(scan_advanced_strobe), .star_trigger_in(1'h0), .trig_bus_in(8'h00),
    .trig_bus_out(trig_bus_out), .trig_bus_oe(trig_bus_oe));
  rss_instr_model i_mdl (.aclk(aclk), .strb(scan_advanced_strobe), .tgl(tgl), .low(low), .fall(fall), .trig(mdl_trig));
  initial forever #50 aclk = ~aclk;
  // ****
  // Expectations, bus tasks and monitor
  // ****
  function automatic int wt(int k);
    return (dly[k] > ST) ? int'(dly[k]) : int'(ST);
  endfunction : wt
  function automatic int fnd(logic [23:0] p);
    for (int k = 0; k < N; k++)
      if (pat[k] === p)
        return k;
    return -1;
  endfunction : fnd
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    `CHK("bresp", e, s_axi_bresp)
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : axr
  task automatic run(input logic [31:0] c, input int n);
    ovr <= 1'h0;
    tgl <= c[3];
    low <= c[4];
    fall <= c[2];
    axw(`RSS_OFF_CTRL, c, 2'h0);
    repeat (100) @(posedge aclk);
    tseen = 1'h0;
    cur = N - 1;
    nld = 0;
    mon = 1'h1;
    axw(`RSS_OFF_CMD, 32'h0000_0002, 2'h0);
    while (nld < n) @(posedge aclk);
  endtask : run
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      final_report();
    end
    if (mon && relay_drive !== r_q)
    begin
      cur = (cur + 1) % N;
      `CHK("entry", cur, fnd(relay_drive))
      if (cur != 0)
        `CHK("trigger", 1'h1, tseen)
      tseen = 1'h0;
      ld = cyc;
      nld++;
    end
    if (mon && scan_advanced_strobe !== s_q && (tgl || scan_advanced_strobe === !low))
    begin
      ac = cyc;
      `CHK("settle", 1'h1, cyc - ld >= wt(cur) * 10 && cyc - ld <= wt(cur) * 10 + 14)
    end
    else if (mon && scan_advanced_strobe !== s_q && !tgl)
      `CHK("width", 1'h1, cyc - ac >= 20 && cyc - ac <= 33)
    if (mon && scan_trigger_input !== t_q && scan_trigger_input === !fall)
      tseen = 1'h1;
    r_q = relay_drive;
    s_q = scan_advanced_strobe;
    t_q = scan_trigger_input;
  end
  initial
  begin
    void'($urandom(32'hF6F310DD));
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    `CHK("oe", 8'h00, trig_bus_oe)
    axr(`RSS_OFF_CTRL);
    `CHK("ctrl", `RSS_CTRL_RST, rd)
    axr(`RSS_OFF_STRBW);
    `CHK("strbw", {16'h0000, `RSS_STRBW_RST}, rd)
    axr(`RSS_OFF_ROUTE);
    `CHK("route", {16'h0000, `RSS_ROUTE_RST}, rd)
    axr(8'h3C);
    `CHK("unmapped", 2'h2, rs)
    axw(8'h3C, 32'hFFFF_FFFF, 2'h2);
    $display("test reset done");
    x = 24'($urandom);
    axw(`RSS_OFF_PAT, {8'h00, x}, 2'h0);
    axw(`RSS_OFF_CMD, 32'h0000_0001, 2'h0);
    `CHK("direct", x, relay_drive)
    axr(`RSS_OFF_DRIVE);
    `CHK("drive", {8'h00, x}, rd)
    ov <= 1'h1;
    repeat (20) @(posedge aclk);
    ov <= 1'h0;
    repeat (20) @(posedge aclk);
    `CHK("no scan", x, relay_drive)
    `CHK("no strobe", 1'h0, scan_advanced_strobe)
    $display("test direct done");
    rr = 8'($urandom_range(1, 255));
    axw(`RSS_OFF_ROUTE, {16'h0000, 8'hFF, rr}, 2'h0);
    @(posedge aclk);
    `CHK("oe", rr, trig_bus_oe)
    ov <= 1'h1;
    repeat (8) @(posedge aclk);
    `CHK("bus high", rr, trig_bus_out & rr)
    ov <= 1'h0;
    repeat (8) @(posedge aclk);
    `CHK("bus low", 8'h00, trig_bus_out & rr)
    axw(`RSS_OFF_ROUTE, 32'h0000_0000, 2'h0);
    @(posedge aclk);
    `CHK("oe off", 8'h00, trig_bus_oe)
    $display("test route done");
    axw(`RSS_OFF_EADDR, 32'h0000_0000, 2'h0);
    for (int k = 0; k < N; k++)
    begin
      pat[k] = 24'($urandom);
      dly[k] = (k == 2) ? ST : 16'($urandom_range(0, 9));
      axw(`RSS_OFF_EPAT, {8'h00, pat[k]}, 2'h0);
      axw(`RSS_OFF_ECFG, {14'h0000, 1'h1, 1'(k != 0), dly[k]}, 2'h0);
    end
    axw(`RSS_OFF_LAST, 32'(N - 1), 2'h0);
    axw(`RSS_OFF_STRBW, 32'h0000_0002, 2'h0);
    run(32'h0000_0001, N);
    do axr(`RSS_OFF_STAT); while (rd[0] !== 1'h0);
    `CHK("hold", pat[N-1], relay_drive)
    `CHK("flag", 1'h1, rd[1])
    axw(`RSS_OFF_STAT, 32'h0000_0002, 2'h2);
    axr(`RSS_OFF_STAT);
    `CHK("flag clear", 1'h0, rd[1])
    repeat (200) @(posedge aclk);
    `CHK("loads", N, nld)
    mon = 1'h0;
    $display("test one-shot done");
    run(32'h0000_001F, N + 2);
    x = relay_drive;
    axw(`RSS_OFF_CMD, 32'h0000_0004, 2'h0);
    repeat (300) @(posedge aclk);
    `CHK("abort", x, relay_drive)
    `CHK("loads", N + 2, nld)
    axr(`RSS_OFF_STAT);
    `CHK("busy", 1'h0, rd[0])
    $display("test cyclic done");
    final_report();
  end
endmodule : test_rss_top
`default_nettype wire
